// ### external_data_move_pkg.sv
// Purpose: shared constants and types for the data-move access unit
// Assumes: APB register window with byte offsets, one word per register
// Notes: external access length is two machine cycles plus the stretch field; on-chip array access is one
package external_data_move_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_PMR = 8'h00;
    localparam logic [7:0] OFS_SELECT = 8'h04;
    localparam logic [7:0] OFS_ACCESS = 8'h08;
    localparam logic [7:0] OFS_PTR0 = 8'h0C;
    localparam logic [7:0] OFS_PTR1 = 8'h10;
    localparam logic [7:0] OFS_CMD = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_PORT = 8'h1C;
    // field positions
    localparam int SRAM_EN_BIT = 0;
    localparam int SELECT_BIT = 0;
    localparam int STRETCH_LSB = 0;
    localparam int STRETCH_W = 3;
    localparam int WAIT_EN_BIT = 3;
    localparam int CMD_DATA_LSB = 8;
    localparam int BUSY_BIT = 0;
    localparam int RDDATA_LSB = 8;
    localparam int PORT2_LSB = 8;
    localparam int PORT4_BIT = 16;
    // reset values
    localparam logic [STRETCH_W-1:0] STRETCH_RST = 3'h1;
    localparam logic [16:0] PORT_RST = 17'h1FFFF;
    // opcodes
    localparam logic [7:0] OP_PTR_DEC = 8'hA5;
    localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_RD = 8'hE0;
    localparam logic [7:0] OP_EXTERNAL_DATA_MOVE_WR = 8'hF0;
    // memory map and timing
    localparam logic [15:0] SRAM_TOP = 16'h03FF;
    localparam int SRAM_DEPTH = 1024;
    localparam logic [1:0] LAST_PHASE = 2'h3;
    localparam int CLOCKS_PER_MC = 4;
    localparam int MIN_MC = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_SRAM, ST_ADDR, ST_STROBE} access_state_t;
endpackage

// ### external_data_move_sram.sv
// Purpose: on-chip data array reached only by data moves
// Assumes: one access per machine cycle, registered read
// Notes: no fetch port exists on this array
`timescale 1ns/1ns
module external_data_move_sram #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic clk_sys, // core clock
    input wire logic wrEn, // write strobe
    input wire logic rdEn, // read strobe
    input wire logic [AW-1:0] addr, // byte index
    input wire logic [7:0] wrData, // write byte
    output logic [7:0] rdData // registered read byte
);
    logic [7:0] mem [DEPTH];

    // write port
    always_ff @(posedge clk_sys)
    begin
        if (wrEn)
        begin
            mem[addr] <= wrData;
        end
    end

    // read port
    always_ff @(posedge clk_sys)
    begin
        if (rdEn)
        begin
            rdData <= mem[addr];
        end
    end
endmodule

// ### active_data_pointer_pair.sv
// Purpose: two 16-bit data pointers with select and decrement
// Assumes: loads and decrement never coincide on one pointer
// Notes: unselected pointer may serve as plain storage
`timescale 1ns/1ns
module active_data_pointer_pair (
    input wire logic clk_sys, // core clock
    input wire logic rstn, // async reset, low
    input wire logic pointerSelect, // 1 picks second pointer
    input wire logic loadFirst, // load first pointer
    input wire logic loadSecond, // load second pointer
    input wire logic [15:0] loadData, // load value
    input wire logic decActive, // decrement active pointer
    output logic [15:0] firstPtr, // first pointer value
    output logic [15:0] secondPtr, // second pointer value
    output logic [15:0] activeDataPointer // selected pointer
);
    // first pointer
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            firstPtr <= 16'h0000;
        else if (loadFirst)
            firstPtr <= loadData;
        else if (decActive && !pointerSelect)
            firstPtr <= firstPtr - 16'h0001;
    end

    // second pointer
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            secondPtr <= 16'h0000;
        else if (loadSecond)
            secondPtr <= loadData;
        else if (decActive && pointerSelect)
            secondPtr <= secondPtr - 16'h0001;
    end

    // pointer selection
    assign activeDataPointer = pointerSelect ? secondPtr : firstPtr;
endmodule

// ### external_data_move_data_access.sv
// Purpose: data-move access unit with on-chip SRAM and external bus
// Assumes: APB slave for software; core clock 25 MHz
// Notes: accesses start on a machine-cycle boundary
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module external_data_move_data_access
    import external_data_move_pkg::*;
(
    input wire logic clk_sys, // core clock
    input wire logic rstn, // async reset, low
    input wire logic [7:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [7:0] p0In, // port 0 pin level
    output logic [7:0] p0Out, // port 0 output
    output logic [7:0] p0DriveN, // port 0 enable, low
    output logic [7:0] p2Out, // port 2 output
    output logic [7:0] p2DriveN, // port 2 enable, low
    output logic aleOut, // address latch strobe
    output logic wrStrobeN, // P3.6 write strobe
    output logic rdStrobeN, // P3.7 read strobe
    input wire logic waitN, // P4.0 wait request, low
    output logic p40Out, // P4.0 output
    output logic p40DriveN // P4.0 enable, low
);
    import external_data_move_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic sramEnReg;
    logic selReg;
    logic [STRETCH_W-1:0] stretchReg;
    logic waitEnReg;
    logic [16:0] portReg;
    logic [7:0] opReg;
    logic [7:0] dataReg;
    logic cmdPendReg;
    logic [7:0] lastDataReg;
    logic [15:0] addrReg;
    logic isWriteReg;
    logic [1:0] phaseReg;
    logic [STRETCH_W-1:0] mcLeftReg;
    logic sramRdDoneReg;
    access_state_t stateReg;
    access_state_t stateNext;
    logic [8:0] syncA;
    logic [8:0] syncB;
    logic [8:0] syncC;
    logic [8:0] filtReg;
    logic [15:0] firstPtr;
    logic [15:0] secondPtr;
    logic [15:0] activePtr;
    logic [7:0] sramRd;
    logic apbAccess;
    logic apbWrite;
    logic apbMapped;
    logic cmdHit;
    logic busy;
    logic busActive;
    logic mcEnd;
    logic waitHeld;
    logic decActive;
    logic sramWr;
    logic sramRdEn;

    // address falls in the enabled on-chip array
    function automatic logic isSramHit(input logic [15:0] a, input logic en);
        isSramHit = en && (a <= SRAM_TOP);
    endfunction

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    assign cmdHit = psel && (paddr == OFS_CMD);
    assign busy = cmdPendReg || (stateReg != ST_IDLE) || sramRdDoneReg; // held until array byte lands
    assign apbMapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_PORT);
    // command write stalls while an access runs
    assign pready = !(cmdHit && pwrite && busy);
    assign pslverr = psel && penable && !apbMapped;
    assign apbAccess = psel && penable && pready && apbMapped;
    assign apbWrite = apbAccess && pwrite;

    // read mux
    always_comb
    begin
        prdata = 32'h00000000;
        case (paddr)
            OFS_PMR: prdata[SRAM_EN_BIT] = sramEnReg;
            OFS_SELECT: prdata[SELECT_BIT] = selReg;
            OFS_ACCESS:
            begin
                prdata[STRETCH_LSB +: STRETCH_W] = stretchReg;
                prdata[WAIT_EN_BIT] = waitEnReg;
            end
            OFS_PTR0: prdata[15:0] = firstPtr;
            OFS_PTR1: prdata[15:0] = secondPtr;
            OFS_CMD: prdata[15:0] = {dataReg, opReg};
            OFS_STATUS:
            begin
                prdata[BUSY_BIT] = busy;
                prdata[RDDATA_LSB +: 8] = lastDataReg;
            end
            OFS_PORT: prdata[16:0] = portReg;
            default: prdata = 32'h00000000;
        endcase
    end

    // power management register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            sramEnReg <= 1'b0;
        else if (apbWrite && paddr == OFS_PMR)
            sramEnReg <= pwdata[SRAM_EN_BIT];
    end

    // pointer select and access length
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            selReg <= 1'b0;
            stretchReg <= STRETCH_RST;
            waitEnReg <= 1'b0;
        end
        else if (apbWrite && paddr == OFS_SELECT)
            selReg <= pwdata[SELECT_BIT];
        else if (apbWrite && paddr == OFS_ACCESS)
        begin
            stretchReg <= pwdata[STRETCH_LSB +: STRETCH_W];
            waitEnReg <= pwdata[WAIT_EN_BIT];
        end
    end

    // general port latches
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            portReg <= PORT_RST;
        else if (apbWrite && paddr == OFS_PORT)
            portReg <= pwdata[16:0];
    end

    // command register; pending set wins over start clear
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            opReg <= 8'h00;
            dataReg <= 8'h00;
            cmdPendReg <= 1'b0;
        end
        else if (apbWrite && paddr == OFS_CMD)
        begin
            opReg <= pwdata[7:0];
            dataReg <= pwdata[CMD_DATA_LSB +: 8];
            cmdPendReg <= (pwdata[7:0] == OP_EXTERNAL_DATA_MOVE_RD) || (pwdata[7:0] == OP_EXTERNAL_DATA_MOVE_WR);
        end
        else if (stateReg == ST_IDLE && mcEnd)
            cmdPendReg <= 1'b0;
    end

    assign decActive = apbWrite && (paddr == OFS_CMD) && (pwdata[7:0] == OP_PTR_DEC);

    // ----------------------------------------
    // data pointers
    // ----------------------------------------
    active_data_pointer_pair u_active_data_pointer (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pointerSelect(selReg),
        .loadFirst(apbWrite && paddr == OFS_PTR0),
        .loadSecond(apbWrite && paddr == OFS_PTR1),
        .loadData(pwdata[15:0]),
        .decActive(decActive),
        .firstPtr(firstPtr),
        .secondPtr(secondPtr),
        .activeDataPointer(activePtr)
    );

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // three stages, change taken once stages two and three agree
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            syncA <= 9'h1FF;
            syncB <= 9'h1FF;
            syncC <= 9'h1FF;
            filtReg <= 9'h1FF;
        end
        else
        begin
            syncA <= {waitN, p0In};
            syncB <= syncA;
            syncC <= syncB;
            filtReg <= (syncC & ~(syncB ^ syncC)) | (filtReg & (syncB ^ syncC));
        end
    end

    assign waitHeld = waitEnReg && !filtReg[8];

    // ----------------------------------------
    // machine cycle timing
    // ----------------------------------------
    // free-running phase, four clocks per machine cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            phaseReg <= 2'h0;
        else
            phaseReg <= phaseReg + 2'h1;
    end

    assign mcEnd = (phaseReg == LAST_PHASE);

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    // next state, evaluated on machine-cycle boundaries
    always_comb
    begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE:
                if (cmdPendReg)
                    stateNext = isSramHit(activePtr, sramEnReg) ? ST_SRAM : ST_ADDR;
            ST_SRAM: stateNext = ST_IDLE;
            ST_ADDR: stateNext = ST_STROBE;
            ST_STROBE:
                if (mcLeftReg == '0 && !waitHeld)
                    stateNext = ST_IDLE;
            default: stateNext = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            stateReg <= ST_IDLE;
        else if (mcEnd)
            stateReg <= stateNext;
    end

    // latched address, direction and stretch count
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            addrReg <= 16'h0000;
            isWriteReg <= 1'b0;
            mcLeftReg <= '0;
        end
        else if (mcEnd && stateReg == ST_IDLE && cmdPendReg)
        begin
            addrReg <= activePtr;
            isWriteReg <= (opReg == OP_EXTERNAL_DATA_MOVE_WR);
        end
        else if (mcEnd && stateReg == ST_ADDR)
            mcLeftReg <= stretchReg;
        else if (mcEnd && stateReg == ST_STROBE && mcLeftReg != '0)
            mcLeftReg <= mcLeftReg - {{(STRETCH_W-1){1'b0}}, 1'b1};
    end

    // ----------------------------------------
    // on-chip array
    // ----------------------------------------
    assign sramWr = (stateReg == ST_SRAM) && mcEnd && isWriteReg;
    assign sramRdEn = (stateReg == ST_SRAM) && mcEnd && !isWriteReg;

    // data moves only; no fetch path and no scratchpad path
    external_data_move_sram #(
        .DEPTH(SRAM_DEPTH),
        .AW(10)
    ) u_sram (
        .clk_sys(clk_sys),
        .wrEn(sramWr),
        .rdEn(sramRdEn),
        .addr(addrReg[9:0]),
        .wrData(dataReg),
        .rdData(sramRd)
    );

    // read data capture from array or bus
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sramRdDoneReg <= 1'b0;
            lastDataReg <= 8'h00;
        end
        else
        begin
            sramRdDoneReg <= sramRdEn;
            if (sramRdDoneReg)
                lastDataReg <= sramRd;
            else if (stateReg == ST_STROBE && mcEnd && stateNext == ST_IDLE && !isWriteReg)
                lastDataReg <= filtReg[7:0];
        end
    end

    // ----------------------------------------
    // external pins
    // ----------------------------------------
    assign busActive = (stateReg == ST_ADDR) || (stateReg == ST_STROBE);

    // ale high in first half of the address cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            aleOut <= 1'b0;
        else
            aleOut <= (stateNext == ST_ADDR && mcEnd && stateReg == ST_IDLE) ||
                (stateReg == ST_ADDR && phaseReg == 2'h0);
    end

    // strobes low through the whole strobe phase
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            wrStrobeN <= 1'b1;
            rdStrobeN <= 1'b1;
        end
        else
        begin
            wrStrobeN <= !(mcEnd ? (stateNext == ST_STROBE && isWriteReg) :
                (stateReg == ST_STROBE && isWriteReg));
            rdStrobeN <= !(mcEnd ? (stateNext == ST_STROBE && !isWriteReg) :
                (stateReg == ST_STROBE && !isWriteReg));
        end
    end

    // port 0: bus with full drive, else open-drain latch
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            p0Out <= 8'h00;
            p0DriveN <= 8'hFF;
        end
        else if (stateReg == ST_ADDR && !aleOut && phaseReg != 2'h0)
        begin
            p0Out <= isWriteReg ? dataReg : 8'h00;
            p0DriveN <= isWriteReg ? 8'h00 : 8'hFF;
        end
        else if (stateReg == ST_ADDR || (stateNext == ST_ADDR && mcEnd))
        begin
            p0Out <= (stateReg == ST_ADDR) ? addrReg[7:0] : activePtr[7:0];
            p0DriveN <= 8'h00;
        end
        else if (stateReg == ST_STROBE && !(mcEnd && stateNext == ST_IDLE))
        begin
            p0Out <= isWriteReg ? dataReg : 8'h00;
            p0DriveN <= isWriteReg ? 8'h00 : 8'hFF;
        end
        else
        begin
            p0Out <= 8'h00;
            p0DriveN <= portReg[7:0];
        end
    end

    // port 2 and P4.0
    always_comb
    begin
        p2Out = busActive ? addrReg[15:8] : 8'h00;
        p2DriveN = busActive ? 8'h00 : portReg[PORT2_LSB +: 8];
        p40Out = 1'b0;
        p40DriveN = waitEnReg ? 1'b1 : portReg[PORT4_BIT];
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [5:0] strobeLenReg;
    logic [3:0] waitSeenReg;

    // strobe length counter for checks
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            strobeLenReg <= '0;
            waitSeenReg <= '0;
        end
        else if (!rdStrobeN || !wrStrobeN)
        begin
            strobeLenReg <= strobeLenReg + 6'h01;
            waitSeenReg <= waitSeenReg | {3'h0, waitHeld};
        end
        else
        begin
            strobeLenReg <= '0;
            waitSeenReg <= '0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_latch;
        aleOut ##1 aleOut ##1 !aleOut;
    endsequence

    sequence s_strobe;
        !rdStrobeN || !wrStrobeN;
    endsequence

    a_sram_route: assert property (stateReg == ST_SRAM |-> sramEnReg && addrReg <= SRAM_TOP)
        else $error("sram access while disabled or out of range");
    a_sram_quiet: assert property (stateReg == ST_SRAM |-> rdStrobeN && wrStrobeN && !aleOut)
        else $error("external pins active on sram access");
    a_high_external: assert property (mcEnd && stateReg == ST_IDLE && cmdPendReg &&
        activePtr > SRAM_TOP |=> stateReg == ST_ADDR)
        else $error("high address not sent external");
    a_latch_first: assert property ($rose(aleOut) |-> p0DriveN == 8'h00 ##0 s_latch ##[1:4] s_strobe)
        else $error("latch strobe not ahead of data strobe");
    a_strobe_length: assert property ($rose(rdStrobeN && wrStrobeN) && waitSeenReg == 4'h0 |->
        strobeLenReg == 6'(CLOCKS_PER_MC * (32'(stretchReg) + 1)))
        else $error("strobe length does not match access length");
    a_ptr_dec: assert property (decActive |=> activePtr == $past(activePtr) - 16'h0001)
        else $error("active pointer not decremented");
    a_port2_addr: assert property (!rdStrobeN || !wrStrobeN |-> p2DriveN == 8'h00 && p2Out == addrReg[15:8])
        else $error("port 2 not driving high address");
    a_wait_input: assert property (waitEnReg |-> p40DriveN)
        else $error("wait pin driven while wait enabled");
    a_cycle_edge: assert property (stateReg != $past(stateReg) |-> phaseReg == 2'h0)
        else $error("state changed off machine cycle boundary");
endmodule

// ### ext_data_ram.sv
// Purpose: external data RAM on the multiplexed port bus
// Assumes: low address latched while the latch strobe is high
// Notes: drives port 0 only while the read strobe is low
`timescale 1ns/1ns
module ext_data_ram (
    input wire logic clk_sys, // core clock
    input wire logic [7:0] p0Pin, // port 0 wire
    input wire logic [7:0] p2Out, // high address
    input wire logic aleOut, // latch strobe
    input wire logic wrStrobeN, // write strobe, low
    input wire logic rdStrobeN, // read strobe, low
    input wire logic [3:0] stallClks, // wait length
    output logic extDrive, // model drives port 0
    output logic [7:0] extData, // driven byte
    output logic waitN // wait request, low
);
    logic [7:0] mem [0:65535];
    logic [7:0] addrLow;
    logic [3:0] stallLeft = 4'h0;
    logic idleLast = 1'b1;
    // address latch, then byte write during the write strobe
    always @(posedge clk_sys)
    begin
        if (aleOut)
            addrLow <= p0Pin;
        if (!wrStrobeN)
            mem[{p2Out, addrLow}] <= p0Pin;
    end
    // wait request held for a set count after a strobe starts
    always @(posedge clk_sys)
    begin
        idleLast <= rdStrobeN & wrStrobeN;
        if (idleLast && !(rdStrobeN & wrStrobeN))
            stallLeft <= stallClks;
        else if (stallLeft != 4'h0)
            stallLeft <= stallLeft - 4'h1;
    end
    assign waitN = (stallLeft == 4'h0);
    assign extDrive = !rdStrobeN;
    assign extData = mem[{p2Out, addrLow}];
endmodule

// ### external_data_move_data_access_tb_top.sv
// Purpose: self-checking bench for the data-move access unit
// Assumes: APB master, external RAM model on the ports
// Notes: released port 0 lines show a moving pattern
`timescale 1ns/1ns
module external_data_move_data_access_tb_top;
    import external_data_move_pkg::*;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv, aleAddr, aleDrv;
    logic [31:0] strobeClk = 32'h0;
    logic [31:0] aleRises = 32'h0;
    logic pready, pslverr, ev, extDrive, waitN, p40Out, p40DriveN, wrStrobeN, rdStrobeN, aleOut;
    logic aleLast = 1'b0;
    logic [7:0] p0Out, p0DriveN, p2Out, p2DriveN, p0Pin, extData;
    logic [7:0] p0Float = 8'h5A;
    logic [3:0] stallClks = 4'h0;
    int n_fail = 0;
    int check_count = 0;
    // sram enable, address, data, expect external
    logic [25:0] rows [6] = '{{1'b0, 16'h0010, 8'hA1, 1'b1}, {1'b1, 16'h0010, 8'hB2, 1'b0},
        {1'b1, 16'h03FF, 8'hC3, 1'b0}, {1'b1, 16'h0400, 8'hD4, 1'b1},
        {1'b0, 16'h03FF, 8'hE5, 1'b1}, {1'b1, 16'hFFFF, 8'hF6, 1'b1}};
    logic [39:0] regs [6] = '{{OFS_PMR, 32'h0}, {OFS_SELECT, 32'h0}, {OFS_ACCESS, 32'h1},
        {OFS_PTR0, 32'h0}, {OFS_PTR1, 32'h0}, {OFS_PORT, 32'h1FFFF}};

    always #20 clk_sys = ~clk_sys;

    external_data_move_data_access u_external_data_move_data_access (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .p0In(p0Pin), .p0Out(p0Out), .p0DriveN(p0DriveN), .p2Out(p2Out),
        .p2DriveN(p2DriveN), .aleOut(aleOut), .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN),
        .waitN(waitN), .p40Out(p40Out), .p40DriveN(p40DriveN));
    ext_data_ram u_ext_data_ram (.clk_sys(clk_sys), .p0Pin(p0Pin), .p2Out(p2Out), .aleOut(aleOut),
        .wrStrobeN(wrStrobeN), .rdStrobeN(rdStrobeN), .stallClks(stallClks), .extDrive(extDrive),
        .extData(extData), .waitN(waitN));

    // port 0 wire: design, then model, else a moving pattern
    always_comb
        for (int i = 0; i < 8; i++)
            p0Pin[i] = !p0DriveN[i] ? p0Out[i] : (extDrive ? extData[i] : p0Float[i]);
    // pin monitor: strobe length, latch pulses, address phase
    always @(posedge clk_sys)
    begin
        p0Float <= ~p0Float;
        aleLast <= aleOut;
        if (!rdStrobeN || !wrStrobeN)
            strobeClk <= strobeClk + 32'h1;
        if (aleOut && !aleLast)
        begin
            aleRises <= aleRises + 32'h1;
            aleAddr <= {16'h0, p2Out, p0Out};
            aleDrv <= {16'h0, p2DriveN, p0DriveN};
        end
    end

    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(rv, exp);
    endtask
    // command, one machine cycle to start, then poll busy
    task automatic mv(input logic [7:0] op, input logic [7:0] d);
        strobeClk = 32'h0;
        aleRises = 32'h0;
        apb(OFS_CMD, 1'b1, {16'h0, d, op});
        repeat (4) @(posedge clk_sys);
        rv = 32'h1;
        for (int k = 0; k < 60 && rv[BUSY_BIT] !== 1'b0; k++)
            apb(OFS_STATUS, 1'b0, 32'h0);
        check({31'h0, rv[BUSY_BIT]}, 32'h0);
    endtask
    task automatic stop_test;
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (rows[i])
        begin
            apb(OFS_PMR, 1'b1, {31'h0, rows[i][25]});
            apb(OFS_PTR0, 1'b1, {16'h0, rows[i][24:9]});
            mv(OP_EXTERNAL_DATA_MOVE_WR, rows[i][8:1]);
            check(aleRises, {31'h0, rows[i][0]});
            check(strobeClk, rows[i][0] ? 32'h8 : 32'h0);
            if (rows[i][0])
            begin
                check(aleAddr, {16'h0, rows[i][24:9]});
                check(aleDrv, 32'h0);
            end
            mv(OP_EXTERNAL_DATA_MOVE_RD, 8'h00);
            check(rv & 32'hFF00, {16'h0, rows[i][8:1], 8'h0});
        end
        // reset in mid-run
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(negedge clk_sys);
        check({20'h0, aleOut, wrStrobeN, rdStrobeN, p2DriveN, p40DriveN}, 32'h7FF);
        @(posedge clk_sys);
        rstn <= 1'b1;
        foreach (regs[i])
            rdck(regs[i][39:32], regs[i][31:0]);
        mv(OP_PTR_DEC, 8'h00);
        rdck(OFS_PTR0, 32'hFFFF);
        for (int s = 0; s < 8; s++)
        begin
            apb(OFS_ACCESS, 1'b1, 32'(s));
            mv(OP_EXTERNAL_DATA_MOVE_WR, 8'(8'h30 + s));
            check(strobeClk, 32'(4 * (s + 1)));
        end
        apb(OFS_PORT, 1'b1, 32'h0FFFF);
        @(negedge clk_sys);
        check({31'h0, p40DriveN}, 32'h0);
        // one stretch cycle so the synchronised wait request is seen in time
        apb(OFS_ACCESS, 1'b1, 32'h9);
        @(negedge clk_sys);
        check({31'h0, p40DriveN}, 32'h1);
        stallClks <= 4'h6;
        mv(OP_EXTERNAL_DATA_MOVE_RD, 8'h00);
        check(rv & 32'hFF00, 32'h3700);
        check({31'h0, strobeClk > 32'h4}, 32'h1);
        check(strobeClk & 32'h3, 32'h0);
        stallClks <= 4'h0;
        apb(OFS_SELECT, 1'b1, 32'h1);
        apb(OFS_PTR1, 1'b1, 32'h2001);
        mv(OP_PTR_DEC, 8'h00);
        rdck(OFS_PTR1, 32'h2000);
        rdck(OFS_PTR0, 32'hFFFF);
        apb(OFS_CMD, 1'b1, 32'h77F0);
        mv(OP_EXTERNAL_DATA_MOVE_RD, 8'h00);
        check(rv & 32'hFF00, 32'h7700);
        check({24'h0, u_ext_data_ram.mem[16'h2000]}, 32'h77);
        apb(8'h20, 1'b0, 32'h0);
        check({31'h0, ev}, 32'h1);
        apb(8'h02, 1'b0, 32'h0);
        check({31'h0, ev}, 32'h1);
        @(negedge clk_sys);
        check({24'h0, p0DriveN}, 32'hFF);
        apb(OFS_PORT, 1'b1, 32'h1FFF0);
        repeat (2) @(negedge clk_sys);
        check({16'h0, p0DriveN, p0Out}, 32'hF000);
        stop_test;
    end
    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        stop_test;
    end
endmodule
